// ---- bench/homing_sequence_dog_z_phase_tb_top.sv ----
// Testbench for the homing sequencer over AHB-Lite.
// Assumes hsq_homing with zero-wait slave and the sensor partner model.
`timescale 1ns/1ns
`include "hsq_params.svh"
module homing_sequence_dog_z_phase_tb_top;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, move_speed, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic op_mode_select_1 = 0, dog_in, z_pulse, move_active, move_reverse;
	logic home_done, homing_incomplete_warning, invert = 0;
	logic [4:0] table_select = 5'h1f;
	int errors = 0, total_checks = 0, cyc = 0;
	typedef struct {logic [31:0] method; logic pol;} hsq_row_type;
	hsq_row_type rows [5] = '{'{32'h6, 0}, '{32'h7, 1}, '{32'h8, 0}, '{32'h16, 1}, '{32'h18, 1}};
	assign hready = hreadyout;
	always #10 hclk = ~hclk;
	hsq_homing i_hsq_homing (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.op_mode_select_1(op_mode_select_1), .table_select(table_select), .dog_in(dog_in),
		.z_pulse(z_pulse), .move_active(move_active), .move_reverse(move_reverse),
		.move_speed(move_speed), .home_done(home_done),
		.homing_incomplete_warning(homing_incomplete_warning));
	hsq_partner i_hsq_partner (.hclk(hclk), .hresetn(hresetn), .move_active(move_active),
		.invert(invert), .dog_in(dog_in), .z_pulse(z_pulse));
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus transfer; waits on hready in both phases
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		repeat (2) @(posedge hclk);
		while (home_done !== 1'b1 && n < 3000) begin
			@(posedge hclk);
			n++;
		end
	endtask
	always @(posedge hclk) if (++cyc > 40000) begin
		errors++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		xfer(0, `HSQ_OFF_METHOD, 0); chk(rd, `HSQ_RST_METHOD);
		chk(hresp, 0);
		xfer(0, `HSQ_OFF_HSPEED, 0); chk(rd, `HSQ_RST_HSPEED);
		xfer(0, `HSQ_OFF_CSPEED, 0); chk(rd, `HSQ_RST_CSPEED);
		xfer(0, `HSQ_OFF_ACCEL, 0); chk(rd, `HSQ_RST_ACCEL);
		xfer(0, 12'h0f0, 0); chk(rd, 0);
		// Homing mode entered before start, table selection still nonzero
		op_mode_select_1 <= 1;
		xfer(1, `HSQ_OFF_CTRL, 1);
		repeat (3) @(posedge hclk);
		chk(move_active, 0);
		table_select <= 5'h00;
		xfer(1, `HSQ_OFF_SHIFT, 100);
		xfer(1, `HSQ_OFF_TRAVEL, 2000);
		foreach (rows[i]) begin
			invert <= rows[i].pol;
			xfer(1, `HSQ_OFF_METHOD, rows[i].method);
			xfer(1, `HSQ_OFF_POLAR, {31'h0, rows[i].pol});
			xfer(1, `HSQ_OFF_COORD, 32'h100 + i);
			xfer(1, `HSQ_OFF_CTRL, 1);
			repeat (5) @(posedge hclk);
			chk(move_active, 1);
			chk(move_reverse, rows[i].method[4]);
			chk(move_speed > 10, 1);
			repeat (55) @(posedge hclk);
			chk(move_speed, 10);
			if (rows[i].method[3:0] == 4'h8) chk(move_reverse, !rows[i].method[4]);
			chk(home_done, 0);
			wait_done();
			chk(home_done, 1);
			xfer(0, `HSQ_OFF_POS, 0); chk(rd, 32'h100 + i);
		end
		// Count type too short to reach creep speed
		xfer(1, `HSQ_OFF_METHOD, 6);
		xfer(1, `HSQ_OFF_TRAVEL, 0);
		xfer(1, `HSQ_OFF_SHIFT, 0);
		xfer(1, `HSQ_OFF_CTRL, 1);
		wait_done();
		@(posedge hclk);
		chk(homing_incomplete_warning, 1);
		xfer(1, `HSQ_OFF_CTRL, 2);
		@(posedge hclk);
		chk(homing_incomplete_warning, 0);
		summarize();
	end
endmodule // homing_sequence_dog_z_phase_tb_top

// ---- bench/hsq_partner.sv ----
// Host side sensors: proximity dog and encoder Z pulse, timed from motion start.
// Assumes move_active from the sequencer and hclk at 50 MHz.
`timescale 1ns/1ns
module hsq_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic move_active,
	input wire logic invert,
	output logic dog_in,
	output logic z_pulse
);
	logic [15:0] cnt_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 16'h0000;
			dog_in <= 1'b0;
			z_pulse <= 1'b0;
		end else begin
			cnt_q <= move_active ? cnt_q + 16'h0001 : 16'h0000;
			// Dog stays active once reached; level set by polarity
			dog_in <= (cnt_q >= 16'h0014) ^ invert;
			// Early pulse before the dog must be ignored
			z_pulse <= (cnt_q == 16'h000a) || (cnt_q == 16'h0046);
		end
	end
endmodule // hsq_partner

// ---- design/hsq_homing.sv ----
// Homing sequencer for count, dog cradle and last Z-phase methods.
// Assumes AHB-Lite single-word transfers and inputs synchronous to hclk.
// Overview of operation
// - Method 6 performs count type front end reference homing.
// - Method 7 performs dog cradle homing.
// - Method 8 performs dog type last Z-phase homing.
// - Travel direction comes from the homing method parameter.
// - Dog input is corrected by polarity before edge detection.
// - Homing speed is used until the dog is detected.
// - Creep speed is used after the dog is detected.
// - Count type applies the shift distance after the dog front end.
// - Count type travels the post-dog distance before the shift.
// - Acceleration constant of table entry 1 serves every method.
// - On completion the current position loads the home coordinate.
// - Dog cradle takes the first Z pulse after the dog front end.
// - Last Z-phase reverses at creep speed after the dog front end.
// - Last Z-phase takes the first Z pulse during the reverse move.
// - Z-based methods offset home from the Z position by the shift.
// - Count type decelerates at front end and ignores Z-phase.
// - Count type warns if it ends before reaching creep speed.
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "hsq_params.svh"
module hsq_homing (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input logic op_mode_select_1,
	input logic [4:0] table_select,
	input logic dog_in,
	input logic z_pulse,
	output logic move_active,
	output logic move_reverse,
	output logic [31:0] move_speed,
	output logic home_done,
	output logic homing_incomplete_warning
);
	hsq_pkg::hsq_state_type st_q;
	hsq_pkg::hsq_state_type st_d;
	logic [31:0] method_q;
	logic [31:0] hspeed_q;
	logic [31:0] cspeed_q;
	logic [31:0] shift_q;
	logic [31:0] coord_q;
	logic [31:0] travel_q;
	logic [31:0] accel_q;
	logic [31:0] pos_q;
	logic polar_q;
	logic warn_q;
	logic done_q;
	logic dog_q;
	logic wr_q;
	logic creep_seen_q;
	logic [11:0] addr_q;
	logic [31:0] dist_q;
	logic [31:0] rdata_q;
	logic [31:0] spd_q;
	logic rev_q;
	logic act_q;
	hsq_ramp_if rif();
	hsq_ramp u_ramp (.hclk(hclk), .hresetn(hresetn), .rp(rif));

	// Address phase capture; single-cycle answer, always OKAY
	wire take = hsel && hready && htrans[1];
	wire wr_hit = wr_q;
	wire [3:0] method = method_q[3:0];
	wire dir_rev = method_q[`HSQ_DIR_BIT];
	wire method_ok = method == `HSQ_METHOD_COUNT || method == `HSQ_METHOD_CRADLE ||
		method == `HSQ_METHOD_LASTZ;
	wire mode_ok = op_mode_select_1 && table_select == 5'h0;
	wire dog_now = dog_in ^ polar_q;
	wire dog_front = dog_now && !dog_q;
	wire at_creep = rif.speed <= cspeed_q;
	wire dist_end = dist_q == 32'h0;
	wire start_pulse = wr_hit && addr_q == `HSQ_OFF_CTRL && hwdata[`HSQ_CTRL_START];
	wire warn_clr = wr_hit && addr_q == `HSQ_OFF_CTRL && hwdata[`HSQ_CTRL_WARN_CLR];
	wire count_end = st_q == hsq_pkg::HSQ_SHIFT && dist_end && method == `HSQ_METHOD_COUNT;
	wire warn_set = count_end && !creep_seen_q;
	// Read data is chosen in the address phase and held in a flop for the data phase
	// Limitation: a read right behind a write to the same word sees the old value
	wire [11:0] rd_addr = haddr[11:0];
	wire [31:0] rd_mux =
		rd_addr == `HSQ_OFF_METHOD ? method_q :
		rd_addr == `HSQ_OFF_HSPEED ? hspeed_q :
		rd_addr == `HSQ_OFF_CSPEED ? cspeed_q :
		rd_addr == `HSQ_OFF_SHIFT ? shift_q :
		rd_addr == `HSQ_OFF_COORD ? coord_q :
		rd_addr == `HSQ_OFF_TRAVEL ? travel_q :
		rd_addr == `HSQ_OFF_POLAR ? {31'h0, polar_q} :
		rd_addr == `HSQ_OFF_ACCEL ? accel_q :
		rd_addr == `HSQ_OFF_STATUS ? {29'h0, warn_q, done_q, act_q} :
		rd_addr == `HSQ_OFF_POS ? pos_q : 32'h0;

	// Sequencer next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			hsq_pkg::HSQ_IDLE: if (start_pulse && mode_ok && method_ok) st_d = hsq_pkg::HSQ_FAST;
			hsq_pkg::HSQ_FAST: if (dog_front) begin
				if (method == `HSQ_METHOD_COUNT) st_d = hsq_pkg::HSQ_TRAVEL;
				else if (method == `HSQ_METHOD_CRADLE) st_d = hsq_pkg::HSQ_SEEKZ;
				else st_d = hsq_pkg::HSQ_REVZ;
			end
			hsq_pkg::HSQ_TRAVEL: if (dist_end) st_d = hsq_pkg::HSQ_SHIFT;
			hsq_pkg::HSQ_SEEKZ: if (z_pulse) st_d = hsq_pkg::HSQ_SHIFT;
			hsq_pkg::HSQ_REVZ: if (z_pulse) st_d = hsq_pkg::HSQ_SHIFT;
			hsq_pkg::HSQ_SHIFT: if (dist_end) st_d = hsq_pkg::HSQ_DONE;
			hsq_pkg::HSQ_DONE: st_d = hsq_pkg::HSQ_IDLE;
			default: st_d = hsq_pkg::HSQ_IDLE;
		endcase
		if (!op_mode_select_1) st_d = hsq_pkg::HSQ_IDLE;
	end

	// Speed target: fast before the dog, creep after
	assign rif.target = st_q == hsq_pkg::HSQ_FAST ? hspeed_q :
		(st_q == hsq_pkg::HSQ_IDLE || st_q == hsq_pkg::HSQ_DONE) ? 32'h0 : cspeed_q;
	assign rif.accel = accel_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 12'h0;
			wr_q <= 1'b0;
		end else begin
			addr_q <= take ? haddr[11:0] : addr_q;
			wr_q <= take && hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			method_q <= `HSQ_RST_METHOD;
			hspeed_q <= `HSQ_RST_HSPEED;
			cspeed_q <= `HSQ_RST_CSPEED;
			accel_q <= `HSQ_RST_ACCEL;
			shift_q <= 32'h0;
			coord_q <= 32'h0;
			travel_q <= 32'h0;
			polar_q <= 1'b0;
		end else if (wr_hit) begin
			if (addr_q == `HSQ_OFF_METHOD) method_q <= hwdata;
			if (addr_q == `HSQ_OFF_HSPEED) hspeed_q <= hwdata;
			if (addr_q == `HSQ_OFF_CSPEED) cspeed_q <= hwdata;
			if (addr_q == `HSQ_OFF_ACCEL) accel_q <= hwdata;
			if (addr_q == `HSQ_OFF_SHIFT) shift_q <= hwdata;
			if (addr_q == `HSQ_OFF_COORD) coord_q <= hwdata;
			if (addr_q == `HSQ_OFF_TRAVEL) travel_q <= hwdata;
			if (addr_q == `HSQ_OFF_POLAR) polar_q <= hwdata[0];
		end
	end

	// Distance counters reload on phase entry; speed is taken as distance per cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= hsq_pkg::HSQ_IDLE;
			dog_q <= 1'b0;
			dist_q <= 32'h0;
			pos_q <= 32'h0;
			creep_seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			dog_q <= dog_now;
			if (st_q != hsq_pkg::HSQ_TRAVEL && st_d == hsq_pkg::HSQ_TRAVEL)
				dist_q <= travel_q;
			else if (st_q != hsq_pkg::HSQ_SHIFT && st_d == hsq_pkg::HSQ_SHIFT)
				dist_q <= shift_q;
			else if (rif.speed >= dist_q)
				dist_q <= 32'h0;
			else
				dist_q <= dist_q - rif.speed;
			if (st_q == hsq_pkg::HSQ_DONE)
				pos_q <= coord_q;
			else if (act_q)
				pos_q <= rev_q ? pos_q - rif.speed : pos_q + rif.speed;
			if (st_q == hsq_pkg::HSQ_FAST)
				creep_seen_q <= 1'b0;
			else if (at_creep && st_q != hsq_pkg::HSQ_IDLE)
				creep_seen_q <= 1'b1;
		end
	end

	// Warning: set wins over software clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			warn_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			warn_q <= warn_set | (warn_q & ~warn_clr);
			done_q <= st_q == hsq_pkg::HSQ_DONE ? 1'b1 : (start_pulse ? 1'b0 : done_q);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rev_q <= 1'b0;
			act_q <= 1'b0;
			spd_q <= 32'h0;
			rdata_q <= 32'h0;
		end else begin
			rev_q <= st_d == hsq_pkg::HSQ_REVZ ? ~dir_rev : dir_rev;
			act_q <= st_d != hsq_pkg::HSQ_IDLE && st_d != hsq_pkg::HSQ_DONE;
			spd_q <= rif.speed;
			rdata_q <= (take && !hwrite) ? rd_mux : rdata_q;
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign move_active = act_q;
	assign move_reverse = rev_q;
	assign move_speed = spd_q;
	assign home_done = done_q;
	assign homing_incomplete_warning = warn_q;

	a_dog_front_seek: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST && dog_front && method == `HSQ_METHOD_CRADLE
		|=> st_q == hsq_pkg::HSQ_SEEKZ) else $error("cradle did not seek Z");
	a_lastz_reverse: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST && dog_front && method == `HSQ_METHOD_LASTZ && op_mode_select_1
		|=> move_reverse == ~dir_rev) else $error("last Z did not reverse");
	a_lastz_z_take: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_REVZ && z_pulse && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_SHIFT && dist_q == $past(shift_q)) else $error("Z not taken");
	a_count_travel: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST && dog_front && method == `HSQ_METHOD_COUNT && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_TRAVEL && dist_q == $past(travel_q)) else $error("no travel");
	a_home_load: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_DONE |=> pos_q == $past(coord_q) && home_done)
		else $error("home coordinate not loaded");
	a_fast_target: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST |-> rif.target == hspeed_q) else $error("fast speed wrong");
	a_creep_target: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q inside {hsq_pkg::HSQ_TRAVEL, hsq_pkg::HSQ_SEEKZ, hsq_pkg::HSQ_REVZ}
		|-> rif.target == cspeed_q) else $error("creep speed wrong");
	a_warn_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		warn_set |=> homing_incomplete_warning) else $error("warning lost");
	a_start_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_IDLE && start_pulse && !mode_ok |=> st_q == hsq_pkg::HSQ_IDLE)
		else $error("started outside homing mode");

	// Sequencing guards; the hold, end and load checks apply only while homing mode stays selected
	a_abort_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		!op_mode_select_1 |=> st_q == hsq_pkg::HSQ_IDLE)
		else $error("no abort on mode drop");
	a_method_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_IDLE && start_pulse && !method_ok |=> st_q == hsq_pkg::HSQ_IDLE)
		else $error("started with unknown method");
	a_fast_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST && !dog_front && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_FAST) else $error("left fast run early");
	// After the dog front end each phase holds until its Z pulse or distance end
	a_cradle_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_SEEKZ && !z_pulse && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_SEEKZ) else $error("cradle left without Z");
	a_revz_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_REVZ && !z_pulse && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_REVZ) else $error("reverse left without Z");
	a_count_no_z: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_TRAVEL && !dist_end && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_TRAVEL) else $error("count travel cut short");
	a_travel_end: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_TRAVEL && dist_end && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_SHIFT && dist_q == $past(shift_q)) else $error("no shift");
	a_shift_load: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_SEEKZ && z_pulse && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_SHIFT && dist_q == $past(shift_q)) else $error("Z shift lost");
	a_shift_done: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_SHIFT && dist_end && op_mode_select_1
		|=> st_q == hsq_pkg::HSQ_DONE) else $error("shift did not finish");
	a_done_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_DONE |=> st_q == hsq_pkg::HSQ_IDLE)
		else $error("done held too long");
	// Direction follows the method word; a write mid-run shows one cycle late
	a_fast_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_FAST && $stable(method_q) |-> move_reverse == dir_rev)
		else $error("fast run direction wrong");
	a_revz_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == hsq_pkg::HSQ_REVZ && $stable(method_q) |-> move_reverse == !dir_rev)
		else $error("reverse creep direction wrong");
	a_dog_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(dog_now) |-> dog_front)
		else $error("dog front end missed");
	// Speed never climbs by more than one acceleration step per cycle
	a_ramp_step: assert property (@(posedge hclk) disable iff (!hresetn)
		rif.speed > $past(rif.speed) |-> rif.speed - $past(rif.speed) <= $past(accel_q))
		else $error("ramp step too large");
	a_warn_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		warn_clr && !warn_set |=> !homing_incomplete_warning)
		else $error("warning not cleared");
endmodule // hsq_homing

// ---- design/hsq_params.svh ----
// Constants for the homing sequencer: register offsets, fields, resets.
// Assumes inclusion by bare name; definitions only.
`ifndef HSQ_PARAMS_SVH
`define HSQ_PARAMS_SVH
`define HSQ_OFF_CTRL 12'h000
`define HSQ_OFF_METHOD 12'h004
`define HSQ_OFF_HSPEED 12'h008
`define HSQ_OFF_CSPEED 12'h00c
`define HSQ_OFF_SHIFT 12'h010
`define HSQ_OFF_COORD 12'h014
`define HSQ_OFF_TRAVEL 12'h018
`define HSQ_OFF_POLAR 12'h01c
`define HSQ_OFF_ACCEL 12'h020
`define HSQ_OFF_STATUS 12'h024
`define HSQ_OFF_POS 12'h028
`define HSQ_METHOD_COUNT 4'h6
`define HSQ_METHOD_CRADLE 4'h7
`define HSQ_METHOD_LASTZ 4'h8
`define HSQ_DIR_BIT 4
`define HSQ_CTRL_START 0
`define HSQ_CTRL_WARN_CLR 1
`define HSQ_RST_METHOD 32'h0000_0006
`define HSQ_RST_HSPEED 32'h0000_0064
`define HSQ_RST_CSPEED 32'h0000_000a
`define HSQ_RST_ACCEL 32'h0000_0004
`endif

// ---- design/hsq_pkg.sv ----
// Types for the homing sequencer.
// Assumes the params header for numeric constants.
package hsq_pkg;
	typedef enum logic [6:0] {
		HSQ_IDLE = 7'b0000001,
		HSQ_FAST = 7'b0000010,
		HSQ_TRAVEL = 7'b0000100,
		HSQ_SEEKZ = 7'b0001000,
		HSQ_REVZ = 7'b0010000,
		HSQ_SHIFT = 7'b0100000,
		HSQ_DONE = 7'b1000000
	} hsq_state_type;
endpackage

// ---- design/hsq_ramp.sv ----
// Speed ramp: slews speed toward target by the accel step each cycle.
// Assumes hclk domain and a nonzero step.
`timescale 1ns/1ns
module hsq_ramp (
	input wire logic hclk,
	input wire logic hresetn,
	hsq_ramp_if.ramp rp
);
	logic [31:0] speed_q;
	wire up = rp.target > speed_q;
	wire [31:0] gap = up ? rp.target - speed_q : speed_q - rp.target;
	wire [31:0] step = (gap < rp.accel) ? gap : rp.accel;
	wire [31:0] speed_d = up ? speed_q + step : speed_q - step;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) speed_q <= 32'h0;
		else speed_q <= speed_d;
	end
	assign rp.speed = speed_q;
endmodule // hsq_ramp

// ---- design/hsq_ramp_if.sv ----
// Interface between sequencer and speed ramp.
// Assumes one clock domain.
`timescale 1ns/1ns
interface hsq_ramp_if;
	logic [31:0] target;
	logic [31:0] accel;
	logic [31:0] speed;
	modport seq (output target, output accel, input speed);
	modport ramp (input target, input accel, output speed);
endinterface
